// ---- ssa_params.svh ----
`ifndef SSA_PARAMS_SVH
`define SSA_PARAMS_SVH
`define SSA_NUM_MASTERS   2
`define SSA_ADDR_W        32
`define SSA_DATA_W        32
`define SSA_CNT_W         8
`define SSA_SHARE_W       4
`define SSA_DEF_SHARES    4'h1
`define SSA_SLV_MAX_BURST 8'h08
`define SSA_BYTES_PER_WD  32'h4
`define SSA_IDLE_CYCLES   8'h01
`define SSA_RR_RESET      0
`endif

// ---- ssa_pkg.sv ----
package ssa_pkg;
	// one master's request bundle
	typedef struct packed {
		logic        req;
		logic        write;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [7:0]  count;
	} ssa_mreq_t;

	// slave-side command bundle
	typedef struct packed {
		logic        req;
		logic        write;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [7:0]  count;
	} ssa_scmd_t;

	typedef enum logic [1:0] {
		SSA_IDLE  = 2'h0,
		SSA_GAP   = 2'h1,
		SSA_ISSUE = 2'h2,
		SSA_XFER  = 2'h3
	} ssa_adp_state_t;
endpackage : ssa_pkg

// ---- ssa_rr_pick.sv ----
`timescale 1ns/10ps
`include "ssa_params.svh"
module ssa_rr_pick #(
	parameter int N = 2
) (
	// request vector and pointer
	input  wire logic [N-1:0]         req_i,
	input  wire logic [$clog2(N)-1:0] ptr_i,
	// choice
	output logic                      any_o,
	output logic [$clog2(N)-1:0]      idx_o
);
	always_comb begin
		any_o = 1'b0;
		idx_o = ptr_i;
		for (int k = N - 1; k >= 0; k--) begin
			if (req_i[(int'(ptr_i) + k) % N]) begin
				any_o = 1'b1;
				idx_o = ($clog2(N))'((int'(ptr_i) + k) % N);
			end
		end
	end
endmodule : ssa_rr_pick

// ---- ssa_burst_adapter.sv ----
`timescale 1ns/10ps
`include "ssa_params.svh"
module ssa_burst_adapter #(
	parameter int CW = 8
) (
	input  wire logic            mclk_i,
	input  wire logic            reset_i,
	// slave abilities
	input  wire logic [CW-1:0]   slv_max_burst_i,
	input  wire logic            slv_burst_ok_i,
	input  wire logic            slv_wrap_i,
	// master burst in
	input  wire ssa_pkg::ssa_mreq_t m_i,
	input  wire logic            start_i,
	// slave word handshake
	input  wire logic            s_wait_i,
	// outputs
	output ssa_pkg::ssa_scmd_t   s_o,
	output logic                 word_done_o,
	output logic                 busy_o,
	output logic                 gap_o
);
	ssa_pkg::ssa_adp_state_t state, next_state;
	logic [CW-1:0] left, next_left;
	logic [CW-1:0] seg, next_seg;
	logic [31:0]   addr, next_addr;
	logic          wr, next_wr;
	logic [CW-1:0] cap, bound;

	// segment length: max, single, or wrap boundary cut
	always_comb begin
		cap   = slv_burst_ok_i ? slv_max_burst_i : CW'(1);
		bound = cap - CW'((addr / `SSA_BYTES_PER_WD) % 32'(cap));
		if (slv_wrap_i && slv_burst_ok_i && bound < cap)
			cap = bound;
	end

	always_comb begin
		next_state = state;
		next_left  = left;
		next_seg   = seg;
		next_addr  = addr;
		next_wr    = wr;
		case (state)
			ssa_pkg::SSA_IDLE: begin
				if (start_i) begin
					next_left  = m_i.count;
					next_addr  = m_i.addr;
					next_wr    = m_i.write;
					next_state = ssa_pkg::SSA_GAP;
				end
			end
			// RULE15: one idle cycle
			ssa_pkg::SSA_GAP: begin
				next_seg   = (left < cap) ? left : cap;
				next_state = ssa_pkg::SSA_ISSUE;
			end
			// RULE12: split into segments
			ssa_pkg::SSA_ISSUE, ssa_pkg::SSA_XFER: begin
				next_state = ssa_pkg::SSA_XFER;
				if (!s_wait_i) begin
					next_left = left - CW'(1);
					next_seg  = seg - CW'(1);
					next_addr = addr + `SSA_BYTES_PER_WD;
					if (left == CW'(1))
						next_state = ssa_pkg::SSA_IDLE;
					// RULE13: singles when no burst
					else if (seg == CW'(1))
						next_state = ssa_pkg::SSA_GAP;
				end
			end
			default: next_state = ssa_pkg::SSA_IDLE;
		endcase
	end

	// RULE14: resequencing machine
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			state <= ssa_pkg::SSA_IDLE;
			left  <= '0;
			seg   <= '0;
			addr  <= '0;
			wr    <= 1'b0;
		end else begin
			state <= next_state;
			left  <= next_left;
			seg   <= next_seg;
			addr  <= next_addr;
			wr    <= next_wr;
		end
	end

	// slave count shows the words left in the current segment
	always_comb begin
		s_o.req   = (state == ssa_pkg::SSA_ISSUE) || (state == ssa_pkg::SSA_XFER);
		s_o.write = wr;
		s_o.addr  = addr;
		s_o.wdata = m_i.wdata;
		s_o.count = seg;
	end
	assign word_done_o = s_o.req && !s_wait_i;
	assign busy_o      = (state != ssa_pkg::SSA_IDLE);
	assign gap_o       = (state == ssa_pkg::SSA_GAP);

	property p_gap_before_issue;
		@(posedge mclk_i) disable iff (reset_i)
		(state == ssa_pkg::SSA_ISSUE) |-> $past(state == ssa_pkg::SSA_GAP);
	endproperty
	a_gap_before_issue: assert property (p_gap_before_issue) else $error("no idle gap"); // RULE15

	property p_seg_cap;
		@(posedge mclk_i) disable iff (reset_i)
		(state == ssa_pkg::SSA_ISSUE) |-> (seg <= slv_max_burst_i || !slv_burst_ok_i);
	endproperty
	a_seg_cap: assert property (p_seg_cap) else $error("segment too long"); // RULE12

	property p_single;
		@(posedge mclk_i) disable iff (reset_i)
		(state == ssa_pkg::SSA_ISSUE && !slv_burst_ok_i) |-> (seg == CW'(1));
	endproperty
	a_single: assert property (p_single) else $error("burst to non-burst slave"); // RULE13
endmodule : ssa_burst_adapter

// ---- ssa_arbiter.sv ----
`timescale 1ns/10ps
`include "ssa_params.svh"
// How it works
// RULE1: look at every master's request and pick the next owner.
// RULE2: grant exactly one master; hold other requesters with wait.
// RULE3: mux owner's address, control, write data; return read data.
// RULE4: only masters targeting this slave are ever stalled here.
// RULE5: each master holds integer shares, one transfer each.
// RULE6: continuous requester gets share-count grants, then passes on.
// RULE7: dropping request forfeits remaining shares; grant moves on.
// RULE8: a new turn starts with full share count.
// RULE9: round-robin among masters requesting now.
// RULE10: master gives burst count when starting a burst.
// RULE11: burst locks the slave until done; shares ignored.
// RULE12: long bursts split into max-length pieces plus remainder.
// RULE13: non-burst slave gets the same number of single transfers.
// RULE14: adapter state machine resequences address and control.
// RULE15: one idle cycle before each slave burst.
// RULE16: wrap-aligned slave bursts split at boundary.
// RULE17: wrap masters must always issue full-length bursts.
// RULE18: shares set per slave, so per arbiter instance.
// RULE19: reset puts pointer at master 0, counters full; here the share counter resets to SSA_DEF_SHARES (1).
module ssa_arbiter #(
	parameter int N  = `SSA_NUM_MASTERS,
	parameter int SW = `SSA_SHARE_W,
	parameter int CW = `SSA_CNT_W
) (
	// clock and reset
	input  wire logic                 mclk_i,
	input  wire logic                 reset_i,
	// per-master configuration
	input  wire logic [N-1:0][SW-1:0] shares_i,
	input  wire logic [N-1:0]         burst_master_i,
	// slave abilities
	input  wire logic [CW-1:0]        slv_max_burst_i,
	input  wire logic                 slv_burst_ok_i,
	input  wire logic                 wrap_aligned_bursts_i,
	// master side
	input  wire ssa_pkg::ssa_mreq_t   m_i [N],
	output logic [N-1:0]              m_wait_o,
	output logic [N-1:0]              m_rvalid_o,
	output logic [31:0]               m_rdata_o,
	// slave side
	output ssa_pkg::ssa_scmd_t        s_o,
	input  wire logic                 s_wait_i,
	input  wire logic                 s_rvalid_i,
	input  wire logic [31:0]          s_rdata_i,
	// status
	output logic [N-1:0]              grant_o,
	output logic                      busy_o
);
	localparam int IW = $clog2(N);

	logic [N-1:0]  req;
	logic [IW-1:0] ptr, next_ptr;
	logic [IW-1:0] owner, next_owner;
	logic          own_valid, next_own_valid;
	logic [SW-1:0] left, next_left;
	logic          pick_any;
	logic [IW-1:0] pick_idx;
	logic [N-1:0]  rd_tag [2];
	logic [N-1:0]  next_rd_tag0;
	logic          adp_done, adp_busy, adp_gap, adp_start;
	ssa_pkg::ssa_mreq_t own_req;

	// RULE1: gather requests
	// RULE4: only this slave's requests count
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_req
			assign req[g] = m_i[g].req;
		end
	endgenerate

	// RULE9: round-robin from pointer
	ssa_rr_pick #(
		.N (N)
	) u_pick (
		.req_i (req),
		.ptr_i (ptr),
		.any_o (pick_any),
		.idx_o (pick_idx)
	);

	assign own_req = m_i[owner];
	wire burst_own = own_valid && burst_master_i[owner];
	wire turn_end  = !adp_busy && own_valid &&
		(!own_req.req || (!burst_own && left == SW'(0)));

	always_comb begin
		next_ptr       = ptr;
		next_owner     = owner;
		next_own_valid = own_valid;
		next_left      = left;
		// RULE5: one share per transfer
		if (own_valid && !burst_own && adp_done && left != SW'(0))
			next_left = left - SW'(1);
		// RULE7: drop forfeits shares
		// RULE6: shares used, pass on
		if (turn_end || (!own_valid && !adp_busy)) begin
			next_own_valid = 1'b0;
			if (pick_any) begin
				next_own_valid = 1'b1;
				next_owner     = pick_idx;
				// RULE8: full shares restored
				// RULE18: this slave's shares
				next_left      = shares_i[pick_idx];
				next_ptr       = IW'((int'(pick_idx) + 1) % N);
			end
		end
	end

	// start the adapter for each owned transfer or burst
	assign adp_start = own_valid && !turn_end && own_req.req && !adp_busy;

	// RULE11: adapter busy holds the lock
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			// RULE19: pointer at master 0
			ptr       <= IW'(`SSA_RR_RESET);
			owner     <= IW'(`SSA_RR_RESET);
			own_valid <= 1'b0;
			left      <= `SSA_DEF_SHARES;
		end else begin
			ptr       <= next_ptr;
			owner     <= next_owner;
			own_valid <= next_own_valid;
			left      <= next_left;
		end
	end

	ssa_pkg::ssa_mreq_t adp_in;
	always_comb begin
		adp_in = own_req;
		// non-burst masters present single transfers
		if (!burst_master_i[owner])
			adp_in.count = CW'(1);
	end

	// RULE16: wrap cut inside adapter
	ssa_burst_adapter #(
		.CW (CW)
	) u_adp (
		.mclk_i          (mclk_i),
		.reset_i         (reset_i),
		.slv_max_burst_i (slv_max_burst_i),
		.slv_burst_ok_i  (slv_burst_ok_i),
		.slv_wrap_i      (wrap_aligned_bursts_i),
		.m_i             (adp_in),
		.start_i         (adp_start),
		.s_wait_i        (s_wait_i),
		.s_o             (s_o),
		.word_done_o     (adp_done),
		.busy_o          (adp_busy),
		.gap_o           (adp_gap)
	);

	// RULE2: single grant, others wait
	// RULE3: master-side wait released per accepted word
	always_comb begin
		for (int k = 0; k < N; k++) begin
			grant_o[k]  = own_valid && (owner == IW'(k));
			m_wait_o[k] = !(grant_o[k] && adp_done);
		end
	end

	// RULE3: read return routed to reader
	always_comb begin
		next_rd_tag0 = rd_tag[0];
		if (s_rvalid_i)
			next_rd_tag0 = '0;
		if (adp_done && !s_o.write)
			next_rd_tag0 = grant_o;
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			rd_tag[0] <= '0;
			rd_tag[1] <= '0;
			m_rdata_o <= '0;
		end else begin
			rd_tag[0] <= next_rd_tag0;
			rd_tag[1] <= s_rvalid_i ? rd_tag[0] : '0;
			m_rdata_o <= s_rvalid_i ? s_rdata_i : m_rdata_o;
		end
	end
	// limitation: one outstanding read per slave
	assign m_rvalid_o = rd_tag[1];
	assign busy_o     = adp_busy;

	property p_onehot_grant;
		@(posedge mclk_i) disable iff (reset_i)
		$onehot0(grant_o);
	endproperty
	a_onehot_grant: assert property (p_onehot_grant) else $error("more than one grant"); // RULE2

	property p_lose_wait;
		@(posedge mclk_i) disable iff (reset_i)
		(req != '0 && grant_o == '0) |-> (m_wait_o == '1);
	endproperty
	a_lose_wait: assert property (p_lose_wait) else $error("ungranted master not stalled"); // RULE2

	property p_lock;
		@(posedge mclk_i) disable iff (reset_i)
		(adp_busy && $past(adp_busy)) |-> $stable(owner);
	endproperty
	a_lock: assert property (p_lock) else $error("owner changed mid burst"); // RULE11

	property p_refill;
		@(posedge mclk_i) disable iff (reset_i)
		($rose(own_valid)) |-> (left == shares_i[owner]);
	endproperty
	a_refill: assert property (p_refill) else $error("turn began without full shares"); // RULE8

	property p_share_limit;
		@(posedge mclk_i) disable iff (reset_i)
		(own_valid && !burst_own && left == SW'(0) && !adp_busy) |=> !adp_busy;
	endproperty
	a_share_limit: assert property (p_share_limit) else $error("transfer beyond shares"); // RULE6

	property p_rr_advance;
		@(posedge mclk_i) disable iff (reset_i)
		($changed(owner) && own_valid) |-> (ptr == IW'((int'(owner) + 1) % N));
	endproperty
	a_rr_advance: assert property (p_rr_advance) else $error("pointer not past owner"); // RULE9

	property p_mux;
		@(posedge mclk_i) disable iff (reset_i)
		(s_o.req) |-> (s_o.wdata == own_req.wdata && s_o.write == $past(s_o.write) || $rose(s_o.req));
	endproperty
	a_mux: assert property (p_mux) else $error("slave data not from owner"); // RULE3

	property p_drop;
		@(posedge mclk_i) disable iff (reset_i)
		(own_valid && !adp_busy && !own_req.req && req != '0) |=> (grant_o != $past(grant_o));
	endproperty
	a_drop: assert property (p_drop) else $error("grant kept after drop"); // RULE7

	property p_gap_rise;
		@(posedge mclk_i) disable iff (reset_i)
		$rose(s_o.req) |-> $past(adp_gap);
	endproperty
	a_gap_rise: assert property (p_gap_rise) else $error("no idle before burst"); // RULE15

	property p_wait_on_done;
		@(posedge mclk_i) disable iff (reset_i)
		(!adp_done) |-> (m_wait_o == '1);
	endproperty
	a_wait_on_done: assert property (p_wait_on_done) else $error("wait dropped early"); // RULE2

	property p_one_release;
		@(posedge mclk_i) disable iff (reset_i)
		$onehot0(~m_wait_o);
	endproperty
	a_one_release: assert property (p_one_release) else $error("two masters released"); // RULE2

	property p_grant_to_req;
		@(posedge mclk_i) disable iff (reset_i)
		(own_valid && grant_o != $past(grant_o)) |-> ((grant_o & $past(req)) != '0);
	endproperty
	a_grant_to_req: assert property (p_grant_to_req) else $error("grant to idle master"); // RULE1

	property p_burst_hold;
		@(posedge mclk_i) disable iff (reset_i)
		(burst_own && adp_busy) |=> (own_valid && $stable(owner));
	endproperty
	a_burst_hold: assert property (p_burst_hold) else $error("burst owner lost slave"); // RULE11

	property p_rvalid_one;
		@(posedge mclk_i) disable iff (reset_i)
		$onehot0(m_rvalid_o);
	endproperty
	a_rvalid_one: assert property (p_rvalid_one) else $error("read data to two masters"); // RULE3

	property p_rdata_route;
		@(posedge mclk_i) disable iff (reset_i)
		(m_rvalid_o != '0) |-> (m_rdata_o == $past(s_rdata_i));
	endproperty
	a_rdata_route: assert property (p_rdata_route) else $error("read data not passed"); // RULE3

	property p_idle_no_owner;
		@(posedge mclk_i) disable iff (reset_i)
		(!own_valid) |-> (!s_o.req);
	endproperty
	a_idle_no_owner: assert property (p_idle_no_owner) else $error("slave driven unowned"); // RULE2

	property p_share_count;
		@(posedge mclk_i) disable iff (reset_i)
		(own_valid && !burst_own && adp_done) |=> (left == $past(left) - SW'(1));
	endproperty
	a_share_count: assert property (p_share_count) else $error("share not spent"); // RULE5

	property p_burst_shares;
		@(posedge mclk_i) disable iff (reset_i)
		(burst_own && adp_done) |=> $stable(left);
	endproperty
	a_burst_shares: assert property (p_burst_shares) else $error("burst spent shares"); // RULE11

	property p_turn_pass;
		@(posedge mclk_i) disable iff (reset_i)
		(own_valid && !burst_own && left == SW'(0) && !adp_busy && (req & ~grant_o) != '0)
			|=> (grant_o != $past(grant_o));
	endproperty
	a_turn_pass: assert property (p_turn_pass) else $error("turn not passed on"); // RULE6
endmodule : ssa_arbiter

// ---- ssa_slave_model.sv ----
`timescale 1ns/10ps
module ssa_slave_model (
	// clock and reset
	input  wire logic               mclk_i,
	input  wire logic               reset_i,
	// command and stall mode
	input  wire ssa_pkg::ssa_scmd_t s_i,
	input  wire logic               slow_i,
	// answers
	output logic                    s_wait_o,
	output logic                    s_rvalid_o,
	output logic [31:0]             s_rdata_o
);
	logic ph;

	// slow mode stalls every other cycle
	assign s_wait_o = slow_i & ph;

	always @(posedge mclk_i) begin
		ph <= reset_i ? 1'b0 : !ph;
		s_rvalid_o <= !reset_i && s_i.req && !s_wait_o && !s_i.write;
		// idle bus shows inverted data so a stale copy never matches
		s_rdata_o <= (s_i.req && !s_wait_o && !s_i.write) ? ~s_i.addr : ~s_rdata_o;
	end
endmodule : ssa_slave_model

// ---- tb_ssa_arbiter.sv ----
`timescale 1ns/10ps
module tb_ssa_arbiter;
	logic               mclk_i = 1'b0;
	logic               reset_i = 1'b1;
	logic [1:0][3:0]    shares;
	logic [1:0]         bmst;
	logic [7:0]         maxb = 8'h08;
	logic               bok, wrap, slow, prev, s_wait, s_rvalid, busy;
	ssa_pkg::ssa_mreq_t m [2];
	ssa_pkg::ssa_scmd_t s;
	logic [1:0]         m_wait, m_rvalid, grant;
	logic [31:0]        m_rdata, s_rdata;
	int                 failures, tests_run, cyc;
	logic [39:0]        ord[$], seg[$], ex[$];
	logic [31:0]        wq[$], rq0[$], rq1[$];

	ssa_arbiter i_ssa_arbiter (.mclk_i(mclk_i), .reset_i(reset_i), .shares_i(shares),
		.burst_master_i(bmst), .slv_max_burst_i(maxb), .slv_burst_ok_i(bok),
		.wrap_aligned_bursts_i(wrap), .m_i(m), .m_wait_o(m_wait), .m_rvalid_o(m_rvalid),
		.m_rdata_o(m_rdata), .s_o(s), .s_wait_i(s_wait), .s_rvalid_i(s_rvalid),
		.s_rdata_i(s_rdata), .grant_o(grant), .busy_o(busy));

	ssa_slave_model i_ssa_slave_model (.mclk_i(mclk_i), .reset_i(reset_i), .s_i(s),
		.slow_i(slow), .s_wait_o(s_wait), .s_rvalid_o(s_rvalid), .s_rdata_o(s_rdata));

	always #2.5 mclk_i = ~mclk_i;

	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_seq(input logic [39:0] got[$], input logic [39:0] exp[$]);
		chk(got.size(), exp.size());
		foreach (exp[i]) chk(got[i], exp[i]);
		chk(40'(wq.size() + rq0.size() + rq1.size()), 40'h0);
		chk(busy, 1'b0);
	endtask : chk_seq

	task automatic wrap_up();
		if (failures == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up

	task automatic rst(input int c);
		reset_i = 1'b1;
		repeat (c) @(negedge mclk_i);
		reset_i = 1'b0;
		ord.delete();
		seg.delete();
	endtask : rst

	// one master transfer; wait is read before the next word is put up
	task automatic xfer(input int k, input logic wr, input logic [31:0] a, input int n,
		input logic bst);
		int i;
		logic acc;
		logic w;
		logic [31:0] wa;
		i = 0;
		acc = 1'b0;
		@(negedge mclk_i);
		m[k] = '{1'b1, wr, a, a ^ 32'hC3C3_0000, bst ? 8'(n) : 8'h01};
		while (i < n) begin
			@(negedge mclk_i);
			w = m_wait[k];
			if (acc) begin
				i++;
				wa = a + 32'(4 * i);
				if (!bst) m[k].addr = wa;
				m[k].wdata = wa ^ 32'hC3C3_0000;
			end
			acc = (w === 1'b0) && (i < n);
			if (acc) begin
				wa = a + 32'(4 * i);
				ord.push_back(40'(k));
				if (wr) wq.push_back(wa ^ 32'hC3C3_0000);
				else if (k == 0) rq0.push_back(~wa);
				else rq1.push_back(~wa);
			end
		end
		m[k].req = 1'b0;
	endtask : xfer

	always @(posedge mclk_i) begin
		if (!reset_i) begin
			if (s.req && !prev) seg.push_back({s.count, s.addr});
			if (s.req) chk(busy, 1'b1);
			if (s.req && !s_wait && s.write) chk(s.wdata, wq.pop_front());
			if (m_rvalid[0]) chk(m_rdata, rq0.pop_front());
			if (m_rvalid[1]) chk(m_rdata, rq1.pop_front());
			chk($countones(grant) > 1, 1'b0);
			for (int k = 0; k < 2; k++) begin
				if (m[k].req && grant[k] !== 1'b1) chk(m_wait[k], 1'b1);
			end
		end
		prev = s.req;
		cyc++;
		if (cyc == 20000) begin
			failures++;
			wrap_up();
		end
	end

	initial begin
		failures = 0;
		tests_run = 0;
		cyc = 0;
		prev = 1'b0;
		m[0] = '0;
		m[1] = '0;
		shares = {4'h3, 4'h2};
		bmst = 2'b00;
		bok = 1'b1;
		wrap = 1'b0;
		slow = 1'b1;
		rst(16);
		fork
			xfer(0, 1'b0, 32'h100, 5, 1'b0);
			xfer(1, 1'b1, 32'h200, 6, 1'b0);
		join
		repeat (4) @(negedge mclk_i);
		chk_seq(ord, '{0, 0, 1, 1, 1, 0, 0, 1, 1, 1, 0});
		shares = {4'h3, 4'h3};
		rst(2);
		fork
			begin
				xfer(0, 1'b0, 32'h300, 1, 1'b0);
				xfer(0, 1'b0, 32'h310, 2, 1'b0);
			end
			xfer(1, 1'b1, 32'h400, 4, 1'b0);
		join
		repeat (4) @(negedge mclk_i);
		chk_seq(ord, '{0, 1, 1, 1, 0, 0, 1});
		shares = {4'h1, 4'h1};
		bmst = 2'b01;
		slow = 1'b0;
		rst(2);
		fork
			xfer(0, 1'b1, 32'h0, 14, 1'b1);
			xfer(1, 1'b0, 32'h500, 2, 1'b0);
		join
		repeat (4) @(negedge mclk_i);
		chk_seq(ord, '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 1});
		chk_seq(seg, '{{8'h08, 32'h0}, {8'h06, 32'h20}, {8'h01, 32'h500},
			{8'h01, 32'h504}});
		bok = 1'b0;
		rst(2);
		xfer(0, 1'b0, 32'h40, 16, 1'b1);
		repeat (4) @(negedge mclk_i);
		for (int i = 0; i < 16; i++) ex.push_back({8'h01, 32'h40 + 32'(4 * i)});
		chk_seq(seg, ex);
		bok = 1'b1;
		wrap = 1'b1;
		rst(2);
		xfer(0, 1'b0, 32'hC, 8, 1'b1);
		repeat (4) @(negedge mclk_i);
		chk_seq(seg, '{{8'h05, 32'hC}, {8'h03, 32'h20}});
		wrap_up();
	end
endmodule : tb_ssa_arbiter
